// >>> rtl/msm_regs.vh
// constants for the operating-mode state machine
`ifndef MSM_REGS_VH
`define MSM_REGS_VH

// internal clock rate
`define MSM_SYS_CLK_MHZ 200

// reset delay: least time, whole cycles
`define MSM_RESET_DELAY_US 10
`define MSM_RESET_DELAY_CYC (`MSM_RESET_DELAY_US * `MSM_SYS_CLK_MHZ)

// continuous filter on the interrupt pin strap: least time, rounded up
`define MSM_CFG_FILTER_NS 500
`define MSM_CFG_FILTER_CYC ((`MSM_CFG_FILTER_NS * `MSM_SYS_CLK_MHZ + 999) / 1000)

// long open watchdog window: longest time, rounded down
`define MSM_LONG_WINDOW_MS 200
`define MSM_LONG_WINDOW_CYC (`MSM_LONG_WINDOW_MS * 1000 * `MSM_SYS_CLK_MHZ)

// watchdog period field value after a reset output release
`define MSM_WD_PERIOD_DEFAULT 3'h4

// mode request encoding in the mode-control bits
`define MSM_REQ_NORMAL 2'h0
`define MSM_REQ_SLEEP 2'h1
`define MSM_REQ_STOP 2'h2

// operating mode codes shown on op_mode
`define MSM_MODE_INIT 3'h0
`define MSM_MODE_NORMAL 3'h1
`define MSM_MODE_STOP 3'h2
`define MSM_MODE_SLEEP 3'h3
`define MSM_MODE_RESTART 3'h4
`define MSM_MODE_FAILSAFE 3'h5

`endif

// >>> rtl/msm_sync.v
// three-stage pin synchroniser with agreement filter
module msm_sync #(
	parameter WIDTH = 1,
	parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
	input wire sys_clk,
	input wire rst_b,
	input wire [WIDTH-1:0] pin_async,
	output reg [WIDTH-1:0] pin_sync
);
	reg [WIDTH-1:0] meta_q; // first stage, read only by stage two
	reg [WIDTH-1:0] s2_q;
	reg [WIDTH-1:0] s3_q;

	// a change is taken once stages two and three agree
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_q <= RST_VAL;
			s2_q <= RST_VAL;
			s3_q <= RST_VAL;
			pin_sync <= RST_VAL;
		end else begin
			meta_q <= pin_async;
			s2_q <= meta_q;
			s3_q <= s2_q;
			pin_sync <= (s2_q & s3_q) | (pin_sync & (s2_q ^ s3_q));
		end
	end
endmodule // msm_sync

// >>> rtl/msm_top.v
// operating-mode state machine with power-on strap latch
// Notes on behaviour
// R1: six modes: init, normal, stop, sleep, restart, failsafe
// R2: restart leaves to normal after reset delay
// R3: failsafe regulator off until wake or overtemp clears
// R4: test strap low in init halts watchdog
// R5: all control arrives from the 16-bit SPI master
// R6: mode bits from SPI, cleared through restart
// R7: power-on enters init with long open window
// R8: pull interrupt pin down, filter, latch on release
// R9: uncleared power-on flag re-arms strap latch
// R10: unstable strap level latches zero
// R11: strap one: watchdog failure goes to restart
// R12: fail outputs after first or second failure
// R13: strap zero: failsafe; config 4 restarts first
// R14: overvoltage with strap one: flag, fail, restart
// R15: overvoltage with strap zero: flag, fail, failsafe
// R16: failure-count and strap bits readable back
// R17: strap latch held until power-on reset
// R18: any SPI command in init gives normal
// R19: controller triggers watchdog inside long window
// R20: missed long window counts failure, enters restart or failsafe as in R11 and R13
// R21: wake events during init are dropped
// R22: restart drives reset low, reloads watchdog period
// R23: stop refuses most writes, sets SPI error
// R24: stop to sleep refused, error, restart
// R25: pending wake flags abort sleep via restart
// R26: filter and delay are clock-cycle counts
// R27: unlisted requests keep the current mode
`include "msm_regs.vh"
module msm_top #(
	parameter [31:0] LONG_WINDOW_CYC = `MSM_LONG_WINDOW_CYC
) (
	input wire sys_clk,
	input wire rst_b,
	input wire int_pin_i,
	input wire test_strap_pin,
	input wire wake_inputs,
	input wire main_regulator_overvoltage,
	input wire overtemp,
	input wire restart_cause,
	input wire cmd_valid,
	input wire cmd_write,
	input wire cmd_mode_req,
	input wire [1:0] cmd_mode,
	input wire cmd_soft_reset,
	input wire cmd_wd_refresh,
	input wire cmd_status_access,
	input wire wd_trigger_fail,
	input wire wake_flags_pending,
	input wire overvoltage_reset_enable,
	input wire fail_count_cfg,
	input wire por_flag_clear,
	input wire ov_flag_clear,
	input wire spi_fail_clear,
	input wire wake_flag_clear,
	output wire int_pin_o,
	output wire int_pin_oe,
	output reg [2:0] op_mode,
	output reg [1:0] mode_ctrl_bits,
	output reg reset_output,
	output reg main_regulator_en,
	output reg fail_outputs,
	output reg dev_mode,
	output reg pin_strap_config,
	output reg fail_count_readback,
	output reg main_regulator_overvoltage_flag,
	output reg spi_fail_flag,
	output reg wake_event_flag,
	output reg por_flag,
	output reg wd_window_open,
	output reg wd_period_load,
	output reg [2:0] wd_period_value
);
	localparam [2:0] ST_INIT = `MSM_MODE_INIT; // R1
	localparam [2:0] ST_NORMAL = `MSM_MODE_NORMAL;
	localparam [2:0] ST_STOP = `MSM_MODE_STOP;
	localparam [2:0] ST_SLEEP = `MSM_MODE_SLEEP;
	localparam [2:0] ST_RESTART = `MSM_MODE_RESTART;
	localparam [2:0] ST_FAILSAFE = `MSM_MODE_FAILSAFE;
	localparam [31:0] RD_LAST_W = `MSM_RESET_DELAY_CYC - 1; // full-width delay end
	localparam [31:0] FLT_LAST_W = `MSM_CFG_FILTER_CYC - 1; // full-width filter end
	localparam [15:0] RD_LAST = RD_LAST_W[15:0]; // R26
	localparam [7:0] FLT_LAST = FLT_LAST_W[7:0];
	localparam [31:0] LW_LAST = LONG_WINDOW_CYC - 32'h1;

	// synchronised pins: int, test, wake, overvoltage, overtemp, cause
	wire [5:0] pin_s;
	wire int_s = pin_s[0];
	wire test_s = pin_s[1];
	wire wake_s = pin_s[2];
	wire ov_s = pin_s[3];
	wire ot_s = pin_s[4];
	wire cause_s = pin_s[5];

	// test strap idles high so a reset does not fake development mode
	msm_sync #(.WIDTH(6), .RST_VAL(6'h02)) u_pin_sync (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.pin_async({restart_cause, overtemp, main_regulator_overvoltage,
			wake_inputs, test_strap_pin, int_pin_i}),
		.pin_sync(pin_s)
	);

	reg [2:0] mode_d; // next operating mode
	reg spi_err_set; // refused command this cycle
	reg [15:0] rd_cnt_q; // reset delay counter
	reg [7:0] flt_cnt_q; // strap filter counter
	reg flt_last_q; // last sampled strap level
	reg flt_ok_q; // strap level stable for the filter time
	reg [31:0] lw_cnt_q; // long open window counter
	reg [1:0] wd_fails_q; // watchdog failures seen, saturating
	reg wake_prev_q;
	reg ov_prev_q;
	reg ot_prev_q;

	// weak pull-down only drives low, never high
	assign int_pin_o = 1'b0;
	wire pd_active = !reset_output && por_flag; // R8 R9
	assign int_pin_oe = pd_active;

	// reset delay ends; restart waits for its cause to clear first
	wire rd_done = !reset_output && (rd_cnt_q == RD_LAST) && !cause_s; // R2
	wire lw_expire = wd_window_open && !dev_mode && (lw_cnt_q == LW_LAST);
	wire wd_live = (op_mode == ST_INIT) || (op_mode == ST_NORMAL) ||
		(op_mode == ST_STOP);
	wire wd_fail_evt = (wd_trigger_fail || lw_expire) && wd_live && !dev_mode; // R4 R20
	wire [1:0] fails_nx = (wd_fails_q == 2'h3) ? 2'h3 : wd_fails_q + 2'h1;
	// config 4 takes its first failure to restart only
	wire wd_to_restart = pin_strap_config || (!fail_count_cfg && fails_nx == 2'h1); // R11 R13
	wire wd_fail_on = fail_count_cfg ? 1'b1 : (fails_nx >= 2'h2); // R12
	wire ov_evt = ov_s && !ov_prev_q;
	wire ov_act = ov_evt && overvoltage_reset_enable && main_regulator_en; // R14 R15
	wire wake_evt = wake_s && !wake_prev_q;
	wire ot_clear = !ot_s && ot_prev_q;
	wire stop_ok = (cmd_mode_req && cmd_mode == `MSM_REQ_NORMAL) || // R5
		cmd_soft_reset || cmd_wd_refresh || cmd_status_access;

	// next-mode selection; failures outrank commands
	always @* begin
		mode_d = op_mode;
		spi_err_set = 1'b0;
		if (wd_fail_evt) begin
			mode_d = wd_to_restart ? ST_RESTART : ST_FAILSAFE; // R11 R13 R20
		end else if (ov_act) begin
			mode_d = pin_strap_config ? ST_RESTART : ST_FAILSAFE; // R14 R15
		end else if (cause_s && (op_mode == ST_NORMAL || op_mode == ST_STOP)) begin
			mode_d = ST_RESTART;
		end else begin
			case (op_mode)
				ST_INIT: begin
					// any command, even illegal, once reset is released
					if (cmd_valid && reset_output)
						mode_d = ST_NORMAL; // R18
				end
				ST_NORMAL: begin
					if (cmd_valid && cmd_soft_reset) begin
						mode_d = ST_INIT;
					end else if (cmd_valid && cmd_mode_req) begin
						if (cmd_mode == `MSM_REQ_STOP)
							mode_d = ST_STOP;
						else if (cmd_mode == `MSM_REQ_SLEEP)
							mode_d = wake_flags_pending ? ST_RESTART : ST_SLEEP; // R25
					end
				end
				ST_STOP: begin
					if (cmd_valid && cmd_soft_reset) begin
						mode_d = ST_INIT;
					end else if (cmd_valid && cmd_mode_req && cmd_mode == `MSM_REQ_SLEEP) begin
						mode_d = ST_RESTART; // R24
						spi_err_set = 1'b1;
					end else if (cmd_valid && cmd_mode_req && cmd_mode == `MSM_REQ_NORMAL) begin
						mode_d = ST_NORMAL;
					end else if (cmd_valid && cmd_write && !stop_ok) begin
						spi_err_set = 1'b1; // R23
					end
				end
				ST_SLEEP: begin
					if (wake_evt)
						mode_d = ST_RESTART;
				end
				ST_RESTART: begin
					if (rd_done)
						mode_d = ST_NORMAL; // R2
				end
				ST_FAILSAFE: begin
					if (wake_evt || ot_clear)
						mode_d = ST_RESTART; // R3
				end
				default: mode_d = ST_INIT; // R27
			endcase
		end
	end

	// mode register, reset output and reset delay counter
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			op_mode <= ST_INIT; // R7
			reset_output <= 1'b0;
			rd_cnt_q <= 16'h0000;
			main_regulator_en <= 1'b1;
		end else begin
			op_mode <= mode_d;
			main_regulator_en <= (mode_d != ST_SLEEP) && (mode_d != ST_FAILSAFE); // R3
			if (mode_d == ST_RESTART && op_mode != ST_RESTART) begin
				reset_output <= 1'b0; // R22
				rd_cnt_q <= 16'h0000;
			end else if (rd_done) begin
				reset_output <= 1'b1; // R22
			end else if (!reset_output) begin
				// hold the count at zero while the restart cause remains
				if (cause_s)
					rd_cnt_q <= 16'h0000;
				else if (rd_cnt_q != RD_LAST)
					rd_cnt_q <= rd_cnt_q + 16'h0001;
			end
		end
	end

	// mode-control bits track accepted requests, cleared by restart
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			mode_ctrl_bits <= `MSM_REQ_NORMAL;
		end else if (mode_d == ST_RESTART) begin
			mode_ctrl_bits <= `MSM_REQ_NORMAL; // R6
		end else if (cmd_valid && cmd_mode_req && mode_d != op_mode) begin
			mode_ctrl_bits <= cmd_mode; // R6
		end
	end

	// continuous strap filter, any level change restarts it
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			flt_cnt_q <= 8'h00;
			flt_last_q <= 1'b0;
			flt_ok_q <= 1'b0;
		end else if (!pd_active) begin
			flt_cnt_q <= 8'h00;
			flt_ok_q <= 1'b0;
			flt_last_q <= int_s;
		end else if (int_s != flt_last_q) begin
			flt_last_q <= int_s; // R8
			flt_cnt_q <= 8'h00;
			flt_ok_q <= 1'b0;
		end else if (flt_cnt_q == FLT_LAST) begin
			flt_ok_q <= 1'b1;
		end else begin
			flt_cnt_q <= flt_cnt_q + 8'h01;
		end
	end

	// strap latch, power-on flag and development mode
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			pin_strap_config <= 1'b0; // R17
			por_flag <= 1'b1;
			dev_mode <= 1'b0;
			fail_count_readback <= 1'b0;
		end else begin
			fail_count_readback <= fail_count_cfg; // R16
			// a power-on reset clears what was latched here; the strap is latched again at each reset release while por_flag is set
			if (rd_done && pd_active)
				pin_strap_config <= flt_ok_q ? flt_last_q : 1'b0; // R8 R9 R10 R17
			if (por_flag_clear)
				por_flag <= 1'b0; // R9
			if (op_mode == ST_INIT && !test_s)
				dev_mode <= 1'b1; // R4
		end
	end

	// long open window and watchdog period reload
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			wd_window_open <= 1'b0;
			lw_cnt_q <= 32'h0000_0000;
			wd_period_load <= 1'b0;
			wd_period_value <= `MSM_WD_PERIOD_DEFAULT;
		end else begin
			wd_period_load <= rd_done; // R22
			if (rd_done) begin
				wd_window_open <= 1'b1; // R7 R22
				lw_cnt_q <= 32'h0000_0000;
				wd_period_value <= `MSM_WD_PERIOD_DEFAULT;
			end else if ((cmd_valid && cmd_wd_refresh) || lw_expire || !wd_live) begin
				wd_window_open <= 1'b0; // R19
			end else if (wd_window_open && !dev_mode) begin
				// halted in development mode: the window never runs out
				lw_cnt_q <= lw_cnt_q + 32'h0000_0001;
			end
		end
	end

	// failure counting, fail outputs and sticky flags; set beats clear
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			wd_fails_q <= 2'h0;
			fail_outputs <= 1'b0;
			main_regulator_overvoltage_flag <= 1'b0;
			spi_fail_flag <= 1'b0;
			wake_event_flag <= 1'b0;
			wake_prev_q <= 1'b0;
			ov_prev_q <= 1'b0;
			ot_prev_q <= 1'b0;
		end else begin
			wake_prev_q <= wake_s;
			ov_prev_q <= ov_s;
			ot_prev_q <= ot_s;
			if (wd_fail_evt)
				wd_fails_q <= fails_nx;
			// leaving restart does not turn the fail outputs off
			if ((wd_fail_evt && wd_fail_on) || ov_act)
				fail_outputs <= 1'b1; // R12 R14 R15
			if (ov_evt)
				main_regulator_overvoltage_flag <= 1'b1; // R14
			else if (ov_flag_clear)
				main_regulator_overvoltage_flag <= 1'b0;
			if (spi_err_set)
				spi_fail_flag <= 1'b1; // R23 R24
			else if (spi_fail_clear)
				spi_fail_flag <= 1'b0;
			if (wake_evt && op_mode != ST_INIT)
				wake_event_flag <= 1'b1; // R21
			else if (wake_flag_clear)
				wake_event_flag <= 1'b0;
		end
	end
endmodule // msm_top

// >>> tb/msm_checker.sv
// port assertions for the mode state machine
`include "msm_regs.vh"
module msm_checker (
	input wire sys_clk,
	input wire rst_b,
	input wire cmd_valid,
	input wire cmd_write,
	input wire cmd_mode_req,
	input wire [1:0] cmd_mode,
	input wire cmd_soft_reset,
	input wire cmd_wd_refresh,
	input wire cmd_status_access,
	input wire [2:0] op_mode,
	input wire [1:0] mode_ctrl_bits,
	input wire reset_output,
	input wire main_regulator_en,
	input wire fail_outputs,
	input wire pin_strap_config,
	input wire spi_fail_flag,
	input wire wake_event_flag,
	input wire wd_period_load,
	input wire [2:0] wd_period_value
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	wire in_stop = op_mode == `MSM_MODE_STOP;  // helper
	wire rst_m = op_mode == `MSM_MODE_RESTART;  // helper
	init_cmd_a: assert property (op_mode == `MSM_MODE_INIT && reset_output && cmd_valid
		&& !cmd_soft_reset |=> op_mode == `MSM_MODE_NORMAL) else $error("init cmd");
	stop_refuse_a: assert property (in_stop && cmd_valid && cmd_write && !cmd_mode_req
		&& !cmd_soft_reset && !cmd_wd_refresh && !cmd_status_access |=> spi_fail_flag && in_stop)
		else $error("stop write");
	stop_sleep_a: assert property (in_stop && cmd_valid && cmd_mode_req
		&& cmd_mode == `MSM_REQ_SLEEP |=> rst_m && spi_fail_flag && !reset_output)
		else $error("stop to sleep");
	restart_bits_a: assert property (rst_m |-> mode_ctrl_bits == 2'h0 && !reset_output)
		else $error("restart bits");
	release_load_a: assert property ($rose(reset_output) |-> wd_period_load
		&& wd_period_value == `MSM_WD_PERIOD_DEFAULT) else $error("period reload");
	restart_exit_a: assert property ($rose(reset_output) && $past(op_mode) == `MSM_MODE_RESTART
		|-> op_mode == `MSM_MODE_NORMAL) else $error("restart exit");
	regulator_off_a: assert property (op_mode == `MSM_MODE_FAILSAFE
		|| op_mode == `MSM_MODE_SLEEP |-> !main_regulator_en) else $error("regulator on");
	fail_hold_a: assert property (fail_outputs |=> fail_outputs) else $error("fail dropped");
	strap_hold_a: assert property (reset_output && $past(reset_output)
		|-> $stable(pin_strap_config)) else $error("strap changed");
	init_wake_a: assert property (op_mode == `MSM_MODE_INIT && $past(op_mode) == `MSM_MODE_INIT
		|-> $stable(wake_event_flag)) else $error("init wake");
	// main scenarios reached
	cover property (op_mode == `MSM_MODE_FAILSAFE);
	cover property (op_mode == `MSM_MODE_SLEEP);
	cover property (in_stop && spi_fail_flag);
endmodule  // msm_checker
bind msm_top msm_checker u_chk (.sys_clk(sys_clk), .rst_b(rst_b), .cmd_valid(cmd_valid),
	.cmd_write(cmd_write), .cmd_mode_req(cmd_mode_req), .cmd_mode(cmd_mode),
	.cmd_soft_reset(cmd_soft_reset), .cmd_wd_refresh(cmd_wd_refresh),
	.cmd_status_access(cmd_status_access), .op_mode(op_mode), .mode_ctrl_bits(mode_ctrl_bits),
	.reset_output(reset_output), .main_regulator_en(main_regulator_en),
	.fail_outputs(fail_outputs), .pin_strap_config(pin_strap_config),
	.spi_fail_flag(spi_fail_flag), .wake_event_flag(wake_event_flag),
	.wd_period_load(wd_period_load), .wd_period_value(wd_period_value));

// >>> tb/msm_mcu_model.sv
// controller side: issues decoded serial commands, one frame per call
module msm_mcu_model (
	input wire sys_clk,
	output logic cmd_valid,
	output logic [6:0] cmd_f
);
	timeunit 1ns;
	timeprecision 1ps;
	// fields: write, mode request, mode, soft reset, refresh, status
	initial cmd_valid = 1'b0;
	initial cmd_f = 7'h00;
	// one frame holds its strobe exactly one cycle
	task send(input logic [6:0] f);
		@(posedge sys_clk) #1;
		cmd_f = f;
		cmd_valid = 1'b1;
		@(posedge sys_clk) #1;
		cmd_valid = 1'b0;
		cmd_f = ~f;  // released fields must not keep their last value
	endtask
endmodule  // msm_mcu_model

// >>> tb/tb_msm_top.sv
// self-checking bench for the mode state machine
`include "msm_regs.vh"
module tb_msm_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk = 1'b0;
	logic rst_b = 1'b0;
	logic strap = 1'b1;  // pin level; an external pull-up beats the weak pull-down
	logic wake = 1'b0;
	logic ov = 1'b0;
	logic ov_en = 1'b0;
	logic cfg = 1'b0;  // failure-count bit
	logic pend = 1'b0;  // uncleared wake flags
	logic wdf = 1'b0;
	logic clr = 1'b0;  // shared flag clear pulse
	logic tst = 1'b1;  // test strap level, low asks for development mode
	logic ot = 1'b0;  // overtemperature level
	logic cause = 1'b0;  // restart cause level
	logic pclr = 1'b0;  // power-on flag clear pulse
	logic oclr = 1'b0;  // overvoltage flag clear pulse
	logic cv;
	logic [6:0] cf;
	wire rst_out, reg_en, fail_o, strap_q, fc_rb, ov_f, spi_f, wk_f;
	wire [2:0] op_mode, wd_val;
	wire [1:0] mbits;
	wire pd_o, pd_oe, dev, por, wwo, wpl;
	int num_errors = 0;
	int checked = 0;
	int cycles = 0;
	always #2.5 sys_clk = ~sys_clk;
	msm_mcu_model mcu (.sys_clk(sys_clk), .cmd_valid(cv), .cmd_f(cf));
	// short watchdog window keeps the run brief
	msm_top #(.LONG_WINDOW_CYC(32'd500)) dut (.sys_clk(sys_clk), .rst_b(rst_b),
		.int_pin_i(strap), .test_strap_pin(tst), .wake_inputs(wake),
		.main_regulator_overvoltage(ov), .overtemp(ot), .restart_cause(cause),
		.cmd_valid(cv), .cmd_write(cf[6]), .cmd_mode_req(cf[5]), .cmd_mode(cf[4:3]),
		.cmd_soft_reset(cf[2]), .cmd_wd_refresh(cf[1]), .cmd_status_access(cf[0]),
		.wd_trigger_fail(wdf), .wake_flags_pending(pend), .overvoltage_reset_enable(ov_en),
		.fail_count_cfg(cfg), .por_flag_clear(pclr), .ov_flag_clear(oclr),
		.spi_fail_clear(clr), .wake_flag_clear(clr), .int_pin_o(pd_o), .int_pin_oe(pd_oe),
		.op_mode(op_mode), .mode_ctrl_bits(mbits), .reset_output(rst_out),
		.main_regulator_en(reg_en), .fail_outputs(fail_o), .dev_mode(dev),
		.pin_strap_config(strap_q), .fail_count_readback(fc_rb),
		.main_regulator_overvoltage_flag(ov_f), .spi_fail_flag(spi_f),
		.wake_event_flag(wk_f), .por_flag(por), .wd_window_open(wwo), .wd_period_load(wpl),
		.wd_period_value(wd_val));
	// hang guard, well above the expected run
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 80000) begin
			num_errors++;
			finish_test();
		end
	end
	task chk(input logic [2:0] s, input logic [2:0] e);
		checked++;
		if (s !== e) begin
			num_errors++;
			$display("BAD %0t saw %h want %h", $time, s, e);
		end
	endtask
	task cm(input logic [2:0] e);
		chk(op_mode, e);
	endtask
	task cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	// wait for reset release; tg keeps the strap level moving
	task up(input logic tg);
		int i;
		for (i = 0; i < 3000 && rst_out !== 1'b1; i++) begin
			if (tg) strap = i[6];
			cyc(1);
		end
		chk(rst_out, 1);
		chk(wpl, 1);
	endtask
	task boot(input logic s, input logic tg);
		strap = s;
		rst_b = 1'b0;
		cyc(4);
		rst_b = 1'b1;
		up(tg);
	endtask
	task rec;
		up(1'b0);
		mcu.send(7'h42);
	endtask
	task pulse(input int w);
		if (w) wdf = 1'b1;
		else clr = 1'b1;
		cyc(1);
		wdf = 1'b0;
		clr = 1'b0;
		cyc(3);
	endtask
	task finish_test;
		if (num_errors == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// power-on: strap latch, pull-down, init wake drop, missed long window
	task t_power_on;
		boot(1'b1, 1'b0);
		chk(strap_q, 1);
		cm(`MSM_MODE_INIT);
		chk(wwo, 1);
		chk(pd_oe, 0);
		chk(por, 1);
		chk(dev, 0);
		wake = 1'b1;
		cyc(8);
		chk(wk_f, 0);
		chk(wpl, 0);
		wake = 1'b0;
		cyc(520);
		cm(`MSM_MODE_RESTART);
		chk(fail_o, 0);
		chk(wwo, 0);
		chk(pd_oe, 1);
		chk(pd_o, 0);
		up(1'b0);
		cm(`MSM_MODE_NORMAL);
		chk(wd_val, 3'h4);
	endtask
	// soft reset back to init, then any command gives normal
	task t_init_cmds;
		mcu.send(7'h44);
		cm(`MSM_MODE_INIT);
		mcu.send(7'h42);
		cm(`MSM_MODE_NORMAL);
		chk(wwo, 0);
		chk(fc_rb, cfg);
	endtask
	// stop refuses writes; stop to sleep goes to restart
	task t_stop;
		mcu.send(7'h70);
		mcu.send(7'h40);
		cm(`MSM_MODE_STOP);
		chk(spi_f, 1);
		pulse(0);
		chk(spi_f, 0);
		mcu.send(7'h68);
		cm(`MSM_MODE_RESTART);
		chk(spi_f, 1);
		chk(mbits, 0);
		chk(pd_oe, 1);
		rec();
	endtask
	// sleep refused with pending flags, then entered and woken
	task t_sleep;
		pend = 1'b1;
		mcu.send(7'h68);
		cm(`MSM_MODE_RESTART);
		rec();
		pend = 1'b0;
		mcu.send(7'h68);
		cm(`MSM_MODE_SLEEP);
		chk(reg_en, 0);
		wake = 1'b1;
		cyc(8);
		cm(`MSM_MODE_RESTART);
		rec();
		chk(wk_f, 1);
		pulse(0);
		chk(wk_f, 0);
		wake = 1'b0;
	endtask
	// strap one: second failure restarts and turns fail outputs on
	task t_wd_strap1;
		pulse(1);
		cm(`MSM_MODE_RESTART);
		chk(fail_o, 1);
		rec();
	endtask
	// overvoltage with reset disabled, flag clear, then enabled
	task t_ov;
		ov = 1'b1;
		cyc(8);
		chk(ov_f, 1);
		cm(`MSM_MODE_NORMAL);
		oclr = 1'b1;
		cyc(1);
		oclr = 1'b0;
		cyc(1);
		chk(ov_f, 0);
		ov = 1'b0;
		ov_en = 1'b1;
		cyc(8);
		ov = 1'b1;
		cyc(8);
		cm(`MSM_MODE_RESTART);
		chk(ov_f, 1);
		ov = 1'b0;
	endtask
	// cleared power-on flag: no pull-down and no relatch on restart
	task t_por;
		rec();
		chk(por, 1);
		pclr = 1'b1;
		cyc(1);
		pclr = 1'b0;
		cyc(1);
		chk(por, 0);
		strap = 1'b0;
		pulse(1);
		cm(`MSM_MODE_RESTART);
		chk(pd_oe, 0);
		rec();
		chk(strap_q, 1);
		strap = 1'b1;
	endtask
	// restart held while its cause stays, left once it clears
	task t_cause;
		cause = 1'b1;
		cyc(8);
		cm(`MSM_MODE_RESTART);
		cyc(2100);
		chk(rst_out, 0);
		cause = 1'b0;
		rec();
		cm(`MSM_MODE_NORMAL);
	endtask
	// strap zero: config 4 restart, then failsafe, wake and overtemp exits
	task t_strap0;
		boot(1'b0, 1'b0);
		chk(strap_q, 0);
		mcu.send(7'h42);
		pulse(1);
		cm(`MSM_MODE_RESTART);
		chk(fail_o, 0);
		rec();
		pulse(1);
		cm(`MSM_MODE_FAILSAFE);
		chk(fail_o, 1);
		chk(reg_en, 0);
		wake = 1'b1;
		cyc(8);
		cm(`MSM_MODE_RESTART);
		rec();
		wake = 1'b0;
		ot = 1'b1;
		cyc(8);
		pulse(1);
		cm(`MSM_MODE_FAILSAFE);
		ot = 1'b0;
		cyc(8);
		cm(`MSM_MODE_RESTART);
		rec();
	endtask
	// test strap low in init: watchdog halted and failures ignored
	task t_dev;
		tst = 1'b0;
		boot(1'b1, 1'b0);
		chk(dev, 1);
		cyc(600);
		cm(`MSM_MODE_INIT);
		chk(wwo, 1);
		pulse(1);
		cm(`MSM_MODE_INIT);
		tst = 1'b1;
	endtask
	// moving strap latches zero; config 2 goes failsafe at once
	task t_unstable;
		boot(1'b1, 1'b1);
		chk(strap_q, 0);
		chk(dev, 0);
		cfg = 1'b1;
		mcu.send(7'h42);
		cm(`MSM_MODE_NORMAL);
		chk(fc_rb, 1);
		pulse(1);
		cm(`MSM_MODE_FAILSAFE);
		chk(fail_o, 1);
	endtask
	initial begin
		t_power_on();
		t_init_cmds();
		t_stop();
		t_sleep();
		t_wd_strap1();
		t_ov();
		t_por();
		t_cause();
		t_strap0();
		t_dev();
		t_unstable();
		finish_test();
	end
endmodule  // tb_msm_top
